// ===== logic/tas_defines.vh
// Purpose: constants for the table access and test-skip execution block
// Assumes: 16-bit instruction words, 21-bit byte pointer, 4-phase instruction cycle
// Notes: AHB-Lite register offsets are byte addresses
`ifndef TAS_DEFINES_VH
`define TAS_DEFINES_VH

`define TAS_OP_TABLE_READ  14'h0002
`define TAS_OP_TABLE_WRITE 14'h0003
`define TAS_OP_TST         7'h33
`define TAS_MODE_NONE      2'h0
`define TAS_MODE_POSTINC   2'h1
`define TAS_MODE_POSTDEC   2'h2
`define TAS_MODE_PREINC    2'h3
`define TAS_IDX_LIMIT      8'h5f
`define TAS_ADDR_PTR       4'h0
`define TAS_ADDR_LATCH     4'h4
`define TAS_ADDR_HOLD      4'h8
`define TAS_ADDR_CTRL      4'hc
`define TAS_CTRL_XINST     0
`define TAS_CTRL_BANK_LSB  8
`define TAS_PTR_RST        21'h000000
`define TAS_BYTE_RST       8'h00

`endif

// ===== logic/tas_prog_mem.v
// Purpose: byte-wide program memory image read by table reads
// Assumes: single clock, registered read data
// Notes: write port loads the image; read data appear one edge after the address
`timescale 1ns/100ps
module tas_prog_mem #(
    parameter AW = 10
) (
    input  wire          sys_clk,
    input  wire          wrEn,
    input  wire [AW-1:0] wrAddr,
    input  wire [7:0]    wrData,
    input  wire [AW-1:0] rdAddr,
    output reg  [7:0]    rdData
);
    reg [7:0] mem [0:(1<<AW)-1];

    // synchronous write, registered read
    always @(posedge sys_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule // tas_prog_mem

// ===== logic/tas_exec.v
// Purpose: executes table read, table write and test-skip-if-zero
// Assumes: one instruction issued per instr_valid pulse; file data read by caller
// Notes: registers over AHB-Lite; each instruction cycle is four sys_clk phases
//
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "tas_defines.vh"
module tas_exec #(
    parameter PTR_W = 21,
    parameter MEM_AW = 10
) (
    input  wire        sys_clk,
    input  wire        rst,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire        instrValid,
    input  wire [15:0] instrWord,
    input  wire        nextIsTwoWord,
    input  wire [7:0]  fileData,
    input  wire        memWrEn,
    input  wire [MEM_AW-1:0] memWrAddr,
    input  wire [7:0]  memWrData,
    output reg         busy_r,
    output reg         flush_r,
    output reg  [11:0] fileAddr_r,
    output reg         fileIndexed_r,
    output reg         skip_r
);
    localparam ST_IDLE = 3'h0;
    localparam ST_TRD  = 3'h1;
    localparam ST_TWR  = 3'h2;
    localparam ST_TST  = 3'h3;
    localparam ST_SKIP = 3'h4;

    reg [PTR_W-1:0] tablePointer_r;
    reg [7:0]       tableLatch_r;
    reg [7:0]       holdReg_r;
    reg [7:0]       ctrl_r;
    reg [3:0]       bankSelect_r;
    reg [2:0]       state_r;
    reg [1:0]       phase_r;
    reg [1:0]       mode_r;
    reg [1:0]       skipLeft_r;
    reg             two_r;
    reg             wrPend_r;
    reg [3:0]       wrAddr_r;
    wire [7:0]      memRd;

    // ****************************************************
    // program memory
    // ****************************************************
    tas_prog_mem #(.AW(MEM_AW)) uMem (
        .sys_clk (sys_clk),
        .wrEn    (memWrEn),
        .wrAddr  (memWrAddr),
        .wrData  (memWrData),
        .rdAddr  (tablePointer_r[MEM_AW-1:0]),
        .rdData  (memRd)
    );

    // ****************************************************
    // decode
    // ****************************************************
    wire isRd  = instrWord[15:2] == `TAS_OP_TABLE_READ;
    wire isWr  = instrWord[15:2] == `TAS_OP_TABLE_WRITE;
    wire isTst = instrWord[15:9] == `TAS_OP_TST;
    wire bankA = instrWord[8];
    wire [7:0] fAddr = instrWord[7:0];
    wire cycEnd = phase_r == 2'h3;
    wire busWr = wrPend_r;
    wire [PTR_W-1:0] ptrInc = tablePointer_r + {{(PTR_W-1){1'b0}}, 1'b1};
    wire [PTR_W-1:0] ptrDec = tablePointer_r - {{(PTR_W-1){1'b0}}, 1'b1};

    // ****************************************************
    // execution state machine
    // ****************************************************
    always @(posedge sys_clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            phase_r <= 2'h0;
            mode_r <= 2'h0;
            two_r <= 1'b0;
            skipLeft_r <= 2'h0;
            tablePointer_r <= `TAS_PTR_RST;
            tableLatch_r <= `TAS_BYTE_RST;
            holdReg_r <= `TAS_BYTE_RST;
            busy_r <= 1'b0;
            flush_r <= 1'b0;
            skip_r <= 1'b0;
            fileAddr_r <= 12'h000;
            fileIndexed_r <= 1'b0;
        end else begin
            phase_r <= (state_r == ST_IDLE) ? 2'h0 : phase_r + 2'h1;
            flush_r <= 1'b0;
            // bus writes to pointer and latch; the holding register is not bus-writable
            if (busWr && wrAddr_r == `TAS_ADDR_PTR) begin
                tablePointer_r <= hwdata[PTR_W-1:0];
            end
            if (busWr && wrAddr_r == `TAS_ADDR_LATCH) begin
                tableLatch_r <= hwdata[7:0];
            end
            case (state_r)
                ST_IDLE: begin
                    skip_r <= 1'b0;
                    if (instrValid) begin
                        mode_r <= instrWord[1:0];
                        two_r <= nextIsTwoWord;
                        if (isRd) begin
                            state_r <= ST_TRD;
                            busy_r <= 1'b1;
                            if (instrWord[1:0] == `TAS_MODE_PREINC) begin
                                tablePointer_r <= ptrInc;
                            end
                        end else if (isWr) begin
                            state_r <= ST_TWR;
                            busy_r <= 1'b1;
                        end else if (isTst) begin
                            state_r <= ST_TST;
                            busy_r <= 1'b1;
                            // access bank or banked address
                            if (bankA) begin
                                fileAddr_r <= {bankSelect_r, fAddr};
                                fileIndexed_r <= 1'b0;
                            end else begin
                                fileAddr_r <= {{4{fAddr[7]}}, fAddr};
                                fileIndexed_r <= ctrl_r[`TAS_CTRL_XINST]
                                    && fAddr <= `TAS_IDX_LIMIT;
                            end
                        end
                    end
                end
                ST_TRD: begin
                    // second cycle end: latch the byte, then post-update
                    if (cycEnd) begin
                        if (skipLeft_r == 2'h1) begin
                            tableLatch_r <= memRd;
                            if (mode_r == `TAS_MODE_POSTINC) begin
                                tablePointer_r <= ptrInc;
                            end else if (mode_r == `TAS_MODE_POSTDEC) begin
                                tablePointer_r <= ptrDec;
                            end
                            state_r <= ST_IDLE;
                            busy_r <= 1'b0;
                            skipLeft_r <= 2'h0;
                        end else begin
                            skipLeft_r <= 2'h1;
                        end
                    end
                end
                ST_TWR: begin
                    if (cycEnd) begin
                        if (skipLeft_r == 2'h1) begin
                            holdReg_r <= tableLatch_r;
                            if (mode_r == `TAS_MODE_POSTINC ||
                                mode_r == `TAS_MODE_PREINC) begin
                                tablePointer_r <= ptrInc;
                            end else if (mode_r == `TAS_MODE_POSTDEC) begin
                                tablePointer_r <= ptrDec;
                            end
                            state_r <= ST_IDLE;
                            busy_r <= 1'b0;
                            skipLeft_r <= 2'h0;
                        end else begin
                            skipLeft_r <= 2'h1;
                        end
                    end
                end
                ST_TST: begin
                    // status flags untouched; only the skip decision leaves
                    if (cycEnd) begin
                        if (fileData == 8'h00) begin
                            skip_r <= 1'b1;
                            flush_r <= 1'b1;
                            skipLeft_r <= two_r ? 2'h2 : 2'h1;
                            state_r <= ST_SKIP;
                        end else begin
                            state_r <= ST_IDLE;
                            busy_r <= 1'b0;
                        end
                    end
                end
                ST_SKIP: begin
                    // one no-op cycle per discarded word
                    if (cycEnd) begin
                        if (skipLeft_r == 2'h1) begin
                            state_r <= ST_IDLE;
                            busy_r <= 1'b0;
                        end else begin
                            flush_r <= 1'b1;
                        end
                        skipLeft_r <= skipLeft_r - 2'h1;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    busy_r <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************
    // AHB-Lite slave: zero wait states, always OKAY
    // ****************************************************
    always @(posedge sys_clk) begin
        if (rst) begin
            wrPend_r <= 1'b0;
            wrAddr_r <= 4'h0;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            ctrl_r <= 8'h00;
            bankSelect_r <= 4'h0;
        end else begin
            if (wrPend_r && wrAddr_r == `TAS_ADDR_CTRL) begin
                ctrl_r <= hwdata[7:0];
                bankSelect_r <= hwdata[`TAS_CTRL_BANK_LSB+3:`TAS_CTRL_BANK_LSB];
            end
            wrPend_r <= hsel && hready && htrans[1] && hwrite;
            wrAddr_r <= haddr[3:0];
            if (hsel && hready && htrans[1] && !hwrite) begin
                case (haddr[3:0])
                    `TAS_ADDR_PTR:   hrdata <= {{(32-PTR_W){1'b0}}, tablePointer_r};
                    `TAS_ADDR_LATCH: hrdata <= {24'h000000, tableLatch_r};
                    `TAS_ADDR_HOLD:  hrdata <= {24'h000000, holdReg_r};
                    `TAS_ADDR_CTRL:  hrdata <= {16'h0000, 4'h0, bankSelect_r,
                                                busy_r, 6'h00, ctrl_r[0]};
                    default:         hrdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // tas_exec

// ===== tb/tas_exec_monitor.sv
// Purpose: port assertions for tas_exec
// Assumes: one clock, sync reset
// Notes: bound to every tas_exec
`timescale 1ns/100ps
`include "tas_defines.vh"
module tas_exec_monitor (
    input wire        sys_clk,
    input wire        rst,
    input wire        instrValid,
    input wire [15:0] instrWord,
    input wire        nextIsTwoWord,
    input wire [7:0]  fileData,
    input wire        busy_r,
    input wire        flush_r,
    input wire [11:0] fileAddr_r,
    input wire        fileIndexed_r,
    input wire        skip_r
);
    reg  [15:0] word_r;
    reg         two_r;
    reg  [1:0]  flushCnt_r;
    wire        issue  = instrValid && !busy_r;
    wire        isTest = word_r[15:9] == `TAS_OP_TST;
    wire        newTst = issue && instrWord[15:9] == `TAS_OP_TST;
    // remembers the issued word and counts flushed words
    always @(posedge sys_clk) begin
        if (rst) begin
            word_r     <= 16'h0000;
            two_r      <= 1'h0;
            flushCnt_r <= 2'h0;
        end else if (issue) begin
            word_r     <= instrWord;
            two_r      <= nextIsTwoWord;
            flushCnt_r <= 2'h0;
        end else if (flush_r) begin
            flushCnt_r <= flushCnt_r + 2'h1;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // two instruction cycles of four clocks each, then idle
    property p_rdTime;
        issue && instrWord[15:2] == `TAS_OP_TABLE_READ |=> busy_r [*8] ##1 !busy_r;
    endproperty
    a_rdTime: assert property (p_rdTime) else $error("table read time");
    property p_wrTime;
        issue && instrWord[15:2] == `TAS_OP_TABLE_WRITE |=> busy_r [*8] ##1 !busy_r;
    endproperty
    a_wrTime: assert property (p_wrTime) else $error("table write time");
    // the decision was taken on the file value of the edge before
    property p_skipZero;
        $rose(skip_r) |-> $past(fileData) == 8'h00 && isTest;
    endproperty
    a_skipZero: assert property (p_skipZero) else $error("skip on nonzero");
    property p_skipFlush;
        $rose(skip_r) |-> ##[0:8] flush_r;
    endproperty
    a_skipFlush: assert property (p_skipFlush) else $error("skip without flush");
    property p_flushInSkip;
        flush_r |-> skip_r && isTest;
    endproperty
    a_flushInSkip: assert property (p_flushInSkip) else $error("flush outside skip");
    property p_flushCount;
        $fell(busy_r) && skip_r |=> flushCnt_r == (two_r ? 2'h2 : 2'h1);
    endproperty
    a_flushCount: assert property (p_flushCount) else $error("flush count");
    property p_noFlush;
        $fell(busy_r) && !skip_r |=> flushCnt_r == 2'h0;
    endproperty
    a_noFlush: assert property (p_noFlush) else $error("flush without skip");
    property p_addrLow;
        newTst |-> ##3 (fileIndexed_r || fileAddr_r[7:0] == word_r[7:0]);
    endproperty
    a_addrLow: assert property (p_addrLow) else $error("file address");
    property p_notIdx;
        newTst && (instrWord[8] || instrWord[7:0] > `TAS_IDX_LIMIT) |-> ##3 !fileIndexed_r;
    endproperty
    a_notIdx: assert property (p_notIdx) else $error("indexed wrongly");
endmodule // tas_exec_monitor
bind tas_exec tas_exec_monitor u_mon (.sys_clk(sys_clk), .rst(rst), .instrValid(instrValid),
    .instrWord(instrWord), .nextIsTwoWord(nextIsTwoWord), .fileData(fileData), .busy_r(busy_r),
    .flush_r(flush_r), .fileAddr_r(fileAddr_r), .fileIndexed_r(fileIndexed_r), .skip_r(skip_r));

// ===== tb/tb_table_access_and_test_skip.sv
// Purpose: self-checking bench for tas_exec
// Assumes: program memory preloaded with address xor 5a
// Notes: registers reached over AHB-Lite
`timescale 1ns/100ps
`include "tas_defines.vh"
module tb_table_access_and_test_skip;
    reg         sys_clk, rst, hsel, hwrite, instrValid, nextIsTwoWord, memWrEn;
    reg  [31:0] haddr, hwdata, rd;
    reg  [1:0]  htrans;
    reg  [15:0] instrWord;
    reg  [7:0]  fileData, memWrData;
    reg  [9:0]  memWrAddr;
    wire [31:0] hrdata;
    wire        hreadyout, hresp, busy_r, flush_r, fileIndexed_r, skip_r;
    wire [11:0] fileAddr_r;
    integer     mismatches, n_tests, i, nFl, nBusy;
    integer     cyc = 0;
    tas_exec DUT (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .instrValid(instrValid), .instrWord(instrWord),
        .nextIsTwoWord(nextIsTwoWord), .fileData(fileData), .memWrEn(memWrEn),
        .memWrAddr(memWrAddr), .memWrData(memWrData), .busy_r(busy_r), .flush_r(flush_r),
        .fileAddr_r(fileAddr_r), .fileIndexed_r(fileIndexed_r), .skip_r(skip_r));
    // ********************
    // clock and hang guard
    // ********************
    initial begin
        sys_clk = 1'h0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            mismatches = mismatches + 1;
            finish_test;
        end
    end
    task check(input [31:0] seen, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // one single word transfer, read data left in rd
    task bus(input wr, input [31:0] a, input [31:0] d);
        begin
            @(posedge sys_clk);
            hsel <= 1'h1;
            haddr <= a;
            hwrite <= wr;
            htrans <= 2'h2;
            @(posedge sys_clk);
            while (!hreadyout) @(posedge sys_clk);
            htrans <= 2'h0;
            hwdata <= d;
            @(posedge sys_clk);
            while (!hreadyout) @(posedge sys_clk);
            rd = hrdata;
        end
    endtask
    // issues one instruction, counts busy and flushed cycles
    task run(input [15:0] w, input two, input [7:0] f, input integer ef);
        begin
            @(posedge sys_clk);
            instrValid <= 1'h1;
            instrWord <= w;
            nextIsTwoWord <= two;
            fileData <= f;
            @(posedge sys_clk);
            instrValid <= 1'h0;
            nFl = 0;
            nBusy = 0;
            // count on falling edges, where the registered outputs have settled
            @(negedge sys_clk);
            while (busy_r) begin
                nBusy = nBusy + 1;
                nFl = nFl + flush_r;
                @(negedge sys_clk);
            end
            check(nFl, ef);
            check(nBusy, (w[15:9] == `TAS_OP_TST) ? 4 + 4 * ef : 8);
        end
    endtask
    task t_reset;
        for (i = 0; i < 20; i = i + 4) begin
            bus(1'h0, i, 32'h0);
            check(rd, 32'h0);
        end
    endtask
    task t_read;
        for (i = 0; i < 4; i = i + 1) begin
            bus(1'h1, `TAS_ADDR_PTR, 32'h001fffff);
            run({`TAS_OP_TABLE_READ, i[1:0]}, 1'h0, 8'h00, 0);
            bus(1'h0, `TAS_ADDR_LATCH, 32'h0);
            check(rd, (i == 3) ? 32'h5a : 32'ha5);
            bus(1'h0, `TAS_ADDR_PTR, 32'h0);
            check(rd, (i == 0) ? 32'h1fffff : (i == 2) ? 32'h1ffffe : 32'h0);
        end
    endtask
    task t_write;
        for (i = 0; i < 4; i = i + 1) begin
            bus(1'h1, `TAS_ADDR_HOLD, 32'hff);
            bus(1'h0, `TAS_ADDR_HOLD, 32'h0);
            check(rd, (i == 0) ? 32'h0 : 32'h2f + i);
            bus(1'h1, `TAS_ADDR_LATCH, 32'h30 + i);
            bus(1'h1, `TAS_ADDR_PTR, 32'h01389a);
            run({`TAS_OP_TABLE_WRITE, i[1:0]}, 1'h0, 8'h00, 0);
            bus(1'h0, `TAS_ADDR_HOLD, 32'h0);
            check(rd, 32'h30 + i);
            bus(1'h0, `TAS_ADDR_PTR, 32'h0);
            check(rd, (i == 2) ? 32'h013899 : (i == 0) ? 32'h01389a : 32'h01389b);
        end
    endtask
    task t_case(input a, input [7:0] f, input [7:0] d, input two, input [11:0] ea, input ei);
        begin
            run({`TAS_OP_TST, a, f}, two, d, (d != 8'h00) ? 0 : two ? 2 : 1);
            check(fileIndexed_r, ei);
            if (!ei) check(fileAddr_r, ea);
        end
    endtask
    task t_test;
        begin
            bus(1'h1, `TAS_ADDR_CTRL, 32'h0501);
            t_case(1'h1, 8'h20, 8'h00, 1'h0, 12'h520, 1'h0);
            t_case(1'h0, 8'h5f, 8'h03, 1'h0, 12'h05f, 1'h1);
            t_case(1'h0, 8'h60, 8'h00, 1'h1, 12'h060, 1'h0);
            bus(1'h1, `TAS_ADDR_CTRL, 32'h0500);
            t_case(1'h0, 8'h5f, 8'h00, 1'h0, 12'h05f, 1'h0);
            t_case(1'h0, 8'ha0, 8'h07, 1'h1, 12'hfa0, 1'h0);
        end
    endtask
    task finish_test;
        begin
            if (mismatches == 0 && n_tests > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    // ********************
    // main sequence
    // ********************
    initial begin
        mismatches = 0;
        n_tests = 0;
        rst = 1'h1;
        hsel = 1'h0;
        hwrite = 1'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        instrValid = 1'h0;
        instrWord = 16'h0;
        nextIsTwoWord = 1'h0;
        fileData = 8'h0;
        memWrEn = 1'h0;
        memWrAddr = 10'h0;
        memWrData = 8'h0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'h0;
        // preload every byte with its address xor 5a
        for (i = 0; i < 1024; i = i + 1) begin
            memWrEn <= 1'h1;
            memWrAddr <= i[9:0];
            memWrData <= i[7:0] ^ 8'h5a;
            @(posedge sys_clk);
        end
        memWrEn <= 1'h0;
        t_reset;
        t_read;
        t_write;
        t_test;
        finish_test;
    end
endmodule // tb_table_access_and_test_skip
